// *** hw/cpu_instr_exec_subset.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpu_instr_exec_subset #(
  parameter bit HAS_MAC = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Instruction issue
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic prefixed,
  input wire logic cond_met,
  input wire logic [7:0] dst_addr,
  input wire logic [31:0] opd_dst,
  input wire logic [15:0] opd_src1,
  input wire logic [15:0] opd_src2,
  input wire logic [15:0] disp,
  input wire logic [23:0] pc_next,
  input wire logic [15:0] stk_word0,
  input wire logic [15:0] stk_word1,
  // Completion and results
  output logic busy_ff,
  output logic done_ff,
  output logic res_wr_ff,
  output logic [1:0] res_size_ff,
  output logic [31:0] res_data_ff,
  output logic cnt_wr_ff,
  output logic [7:0] cnt_data_ff,
  // Program flow
  output logic pc_load_ff,
  output logic [23:0] pc_ff,
  output logic [15:0] sp_ff,
  // Stack write
  output logic mem_wr_ff,
  output logic [15:0] mem_addr_ff,
  output logic [15:0] mem_wdata_ff,
  // Processor state
  output logic [7:0] processor_flag_word_ff,
  output logic [7:0] irq_enable_low_ff,
  output logic [7:0] irq_enable_high_ff,
  output logic [7:0] window_select_reg_ff,
  output logic irq_inhibit_ff,
  output logic [31:0] acc_ff,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_ff
);
  exec_subset_pkg::state_e state_ff;
  logic [31:0] norm_val_ff;
  logic [4:0] norm_cnt_ff;
  logic [1:0] ctrl_ff;
  logic [5:0] op6;
  logic go, plain, is_ldse, is_ldze, is_long_relative_branch, is_sbr, is_flip, is_inv, is_merge;
  logic prod_w2, prod_w3, prod_b2, prod_b3, is_prod, prod_3, prod_byte, mac_go;
  logic is_norm, is_popw, is_pushw, is_rall, is_rflag, is_restore, norm_fin, fin;
  logic [15:0] prod_a, prod_b, inv_val, merge_val;
  logic [31:0] product;
  logic [23:0] long_relative_branch_tgt, sbr_tgt;
  // Zero and negative from a word or byte result
  function automatic logic [1:0] zn_of(input logic [15:0] v, input logic is_b);
    logic z;
    logic n;
    z = is_b ? (v[7:0] == 8'h00) : (v == 16'h0000);
    n = is_b ? v[7] : v[15];
    return {z, n};
  endfunction
  // Decode
  assign go = start && (state_ff == exec_subset_pkg::S_IDLE);
  assign op6 = opcode[7:2];
  assign plain = go && !prefixed;
  assign is_ldse = plain && (op6 == exec_subset_pkg::OP6_LOAD_SEXT);
  assign is_ldze = plain && (op6 == exec_subset_pkg::OP6_LOAD_ZEXT);
  assign is_long_relative_branch = plain && (opcode == exec_subset_pkg::OPC_LONG_BR);
  assign is_sbr = plain && (opcode[7:4] == exec_subset_pkg::OPN_SHORT_BR) && cond_met;
  assign prod_w2 = op6 == exec_subset_pkg::OP6_PROD_W2;
  assign prod_w3 = op6 == exec_subset_pkg::OP6_PROD_W3;
  assign prod_b2 = op6 == exec_subset_pkg::OP6_PROD_B2;
  assign prod_b3 = op6 == exec_subset_pkg::OP6_PROD_B3;
  assign is_prod = go && (prod_w2 || prod_w3 || prod_b2 || prod_b3);
  assign prod_3 = prod_w3 || prod_b3;
  assign prod_byte = prod_b2 || prod_b3;
  assign is_flip = plain && ((opcode == exec_subset_pkg::OPC_FLIP_W) ||
                             (opcode == exec_subset_pkg::OPC_FLIP_B));
  assign is_inv = plain && ((opcode == exec_subset_pkg::OPC_INV_W) ||
                            (opcode == exec_subset_pkg::OPC_INV_B));
  assign is_merge = plain && ((op6 == exec_subset_pkg::OP6_MERGE_W) ||
                              (op6 == exec_subset_pkg::OP6_MERGE_B));
  assign is_norm = plain && (opcode == exec_subset_pkg::OPC_JUSTIFY);
  assign is_popw = plain && (op6 == exec_subset_pkg::OP6_POP_W);
  assign is_pushw = plain && (op6 == exec_subset_pkg::OP6_PUSH_W);
  assign is_rall = plain && (opcode == exec_subset_pkg::OPC_RESTORE_ALL);
  assign is_rflag = plain && (opcode == exec_subset_pkg::OPC_RESTORE_FLAG);
  assign is_restore = is_rall || is_rflag;
  assign norm_fin = (state_ff == exec_subset_pkg::S_NORM) &&
                    (norm_val_ff[31] || (norm_cnt_ff == exec_subset_pkg::JUSTIFY_MAX));
  assign fin = (go && !is_norm) || norm_fin;
  // Multiplier operands: two-operand forms use the destination
  assign prod_a = prod_3 ? opd_src1 : opd_dst[15:0];
  assign prod_b = prod_3 ? opd_src2 : opd_src1;
  assign mac_go = is_prod && prod_w3 && HAS_MAC &&
                  ctrl_ff[exec_subset_pkg::CTRL_MAC_BIT] &&
                  (dst_addr <= exec_subset_pkg::MAC_ADDR_TOP); // [RULE6]
  product_unit u_product (
    .a(prod_a),
    .b(prod_b),
    .is_signed(prefixed),
    .is_byte(prod_byte),
    .product(product)
  );
  // Branch targets
  assign long_relative_branch_tgt = ctrl_ff[exec_subset_pkg::CTRL_MODE_BIT] ?
                    pc_next + {{8{disp[15]}}, disp} :
                    {pc_next[23:16], pc_next[15:0] + disp}; // [RULE3]
  assign sbr_tgt = pc_next + {{16{disp[7]}}, disp[7:0]}; // [RULE22]
  assign inv_val = ~opd_dst[15:0];
  assign merge_val = opd_dst[15:0] | opd_src1;
  // Sequencing and the iterative justify
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_ff <= exec_subset_pkg::S_IDLE;
      busy_ff <= 1'b0;
      norm_val_ff <= '0;
      norm_cnt_ff <= '0;
      cnt_wr_ff <= 1'b0;
      cnt_data_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_wr_ff <= 1'b0;
      done_ff <= fin;
      case (state_ff)
        exec_subset_pkg::S_IDLE: begin
          if (is_norm) begin
            state_ff <= exec_subset_pkg::S_NORM;
            busy_ff <= 1'b1;
            norm_val_ff <= opd_dst;
            norm_cnt_ff <= '0;
          end
        end
        exec_subset_pkg::S_NORM: begin
          if (norm_fin) begin
            state_ff <= exec_subset_pkg::S_IDLE;
            busy_ff <= 1'b0;
            cnt_wr_ff <= 1'b1;
            cnt_data_ff <= {3'h0, norm_cnt_ff}; // [RULE13]
          end else begin
            norm_val_ff <= {norm_val_ff[30:0], 1'b0}; // [RULE13]
            norm_cnt_ff <= norm_cnt_ff + 5'h01;
          end
        end
        default: begin
          state_ff <= exec_subset_pkg::S_IDLE;
          busy_ff <= 1'b0;
        end
      endcase
    end
  end
  // Operand results
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      res_wr_ff <= 1'b0;
      res_size_ff <= exec_subset_pkg::SZ_WORD;
      res_data_ff <= '0;
    end else begin
      res_wr_ff <= 1'b0;
      if (is_ldse) begin
        res_wr_ff <= 1'b1;
        res_size_ff <= exec_subset_pkg::SZ_WORD;
        res_data_ff <= {16'h0000, {8{opd_src1[7]}}, opd_src1[7:0]}; // [RULE1]
      end else if (is_ldze) begin
        res_wr_ff <= 1'b1;
        res_size_ff <= exec_subset_pkg::SZ_WORD;
        res_data_ff <= {16'h0000, 8'h00, opd_src1[7:0]}; // [RULE2]
      end else if (is_prod) begin
        // [RULE4] [RULE5] [RULE7] [RULE8] [RULE9]
        res_wr_ff <= 1'b1;
        res_size_ff <= prod_byte ? exec_subset_pkg::SZ_WORD : exec_subset_pkg::SZ_LONG;
        res_data_ff <= prod_byte ? {16'h0000, product[15:0]} : product;
      end else if (is_flip) begin
        res_wr_ff <= 1'b1;
        res_size_ff <= opcode[4] ? exec_subset_pkg::SZ_BYTE : exec_subset_pkg::SZ_WORD;
        res_data_ff <= opcode[4] ? {24'h00_0000, 8'h00 - opd_dst[7:0]} :
                                   {16'h0000, 16'h0000 - opd_dst[15:0]}; // [RULE11]
      end else if (is_inv) begin
        res_wr_ff <= 1'b1;
        res_size_ff <= opcode[4] ? exec_subset_pkg::SZ_BYTE : exec_subset_pkg::SZ_WORD;
        res_data_ff <= opcode[4] ? {24'h00_0000, inv_val[7:0]} :
                                   {16'h0000, inv_val}; // [RULE15]
      end else if (is_merge) begin
        res_wr_ff <= 1'b1;
        res_size_ff <= opcode[4] ? exec_subset_pkg::SZ_BYTE : exec_subset_pkg::SZ_WORD;
        res_data_ff <= opcode[4] ? {24'h00_0000, merge_val[7:0]} :
                                   {16'h0000, merge_val}; // [RULE16]
      end else if (is_popw) begin
        res_wr_ff <= 1'b1;
        res_size_ff <= exec_subset_pkg::SZ_WORD;
        res_data_ff <= {16'h0000, stk_word0}; // [RULE17]
      end else if (norm_fin) begin
        res_wr_ff <= 1'b1;
        res_size_ff <= exec_subset_pkg::SZ_LONG;
        res_data_ff <= norm_val_ff; // [RULE13]
      end
    end
  end
  // Flag word; multiplies leave the round flag as it was [RULE10]
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      processor_flag_word_ff <= exec_subset_pkg::PAIR_RST;
    end else if (is_inv) begin
      {processor_flag_word_ff[exec_subset_pkg::FLG_Z],
       processor_flag_word_ff[exec_subset_pkg::FLG_N]} <= zn_of(inv_val, opcode[4]);
      processor_flag_word_ff[exec_subset_pkg::FLG_C] <= 1'b0; // [RULE15]
      processor_flag_word_ff[exec_subset_pkg::FLG_V] <= 1'b0;
      processor_flag_word_ff[exec_subset_pkg::FLG_TRAP] <= 1'b0;
    end else if (is_merge) begin
      {processor_flag_word_ff[exec_subset_pkg::FLG_Z],
       processor_flag_word_ff[exec_subset_pkg::FLG_N]} <= zn_of(merge_val, opcode[4]);
      processor_flag_word_ff[exec_subset_pkg::FLG_C] <= 1'b0; // [RULE16]
      processor_flag_word_ff[exec_subset_pkg::FLG_V] <= 1'b0;
    end else if (is_rflag) begin
      processor_flag_word_ff <= stk_word0[15:8]; // [RULE19]
    end else if (is_rall) begin
      processor_flag_word_ff <= stk_word1[15:8]; // [RULE18]
    end else if (norm_fin) begin
      processor_flag_word_ff[exec_subset_pkg::FLG_C] <= 1'b0; // [RULE13]
      processor_flag_word_ff[exec_subset_pkg::FLG_Z] <= ~norm_val_ff[31]; // [RULE14]
    end
  end
  // Interrupt enables, window select and the post-restore hold
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irq_enable_low_ff <= exec_subset_pkg::PAIR_RST;
      irq_enable_high_ff <= exec_subset_pkg::PAIR_RST;
      window_select_reg_ff <= exec_subset_pkg::PAIR_RST;
      irq_inhibit_ff <= 1'b0;
    end else begin
      if (is_rflag) begin
        irq_enable_low_ff <= stk_word0[7:0]; // [RULE19]
      end else if (is_rall) begin
        irq_enable_high_ff <= stk_word0[15:8]; // [RULE18]
        window_select_reg_ff <= stk_word0[7:0];
        irq_enable_low_ff <= stk_word1[7:0];
      end
      if (is_restore) begin
        irq_inhibit_ff <= 1'b1; // [RULE20]
      end else if (fin) begin
        irq_inhibit_ff <= 1'b0; // [RULE20]
      end
    end
  end
  // Stack pointer and pushed word
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sp_ff <= exec_subset_pkg::SP_RST;
      mem_wr_ff <= 1'b0;
      mem_addr_ff <= '0;
      mem_wdata_ff <= '0;
    end else begin
      mem_wr_ff <= 1'b0;
      if (reg_wr && (reg_addr == exec_subset_pkg::REG_SP)) begin
        sp_ff <= reg_wdata[15:0];
      end
      if (is_popw || is_rflag) begin
        sp_ff <= sp_ff + exec_subset_pkg::SP_STEP; // [RULE17] [RULE19]
      end else if (is_rall) begin
        sp_ff <= sp_ff + exec_subset_pkg::SP_STEP2; // [RULE18]
      end else if (is_pushw) begin
        sp_ff <= sp_ff - exec_subset_pkg::SP_STEP; // [RULE21]
        mem_wr_ff <= 1'b1;
        mem_addr_ff <= sp_ff - exec_subset_pkg::SP_STEP; // [RULE21]
        mem_wdata_ff <= opd_src1;
      end
    end
  end
  // Program counter
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pc_ff <= exec_subset_pkg::PC_RST;
      pc_load_ff <= 1'b0;
    end else begin
      pc_load_ff <= is_long_relative_branch || is_sbr;
      if (is_long_relative_branch) begin
        pc_ff <= long_relative_branch_tgt; // [RULE3]
      end else if (is_sbr) begin
        pc_ff <= sbr_tgt; // [RULE22]
      end else if (fin) begin
        pc_ff <= pc_next; // [RULE12]
      end
    end
  end
  // Accumulator
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      acc_ff <= '0;
    end else if (mac_go) begin
      acc_ff <= (dst_addr[exec_subset_pkg::MAC_CLR_BIT] ? 32'h0000_0000 : acc_ff) + product;
    end
  end
  // Register port
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_ff <= exec_subset_pkg::CTRL_RST;
      reg_rdata_ff <= '0;
    end else begin
      if (reg_wr && (reg_addr == exec_subset_pkg::REG_CTRL)) begin
        ctrl_ff <= reg_wdata[1:0];
      end
      reg_rdata_ff <= '0;
      if (reg_rd) begin
        case (reg_addr)
          exec_subset_pkg::REG_CTRL: reg_rdata_ff <= {30'h0000_0000, ctrl_ff};
          exec_subset_pkg::REG_ACC_LO: reg_rdata_ff <= {16'h0000, acc_ff[15:0]};
          exec_subset_pkg::REG_ACC_HI: reg_rdata_ff <= {16'h0000, acc_ff[31:16]};
          exec_subset_pkg::REG_SP: reg_rdata_ff <= {16'h0000, sp_ff};
          default: reg_rdata_ff <= '0;
        endcase
      end
    end
  end
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence seq_justify_go;
    go && is_norm && (opd_dst == 32'h0000_0000);
  endsequence
  sequence seq_justify_end;
    ##[33:33] (done_ff && cnt_wr_ff && (cnt_data_ff == 8'h1f));
  endsequence
  chk_sext_load: assert property (is_ldse |=> res_wr_ff && // [RULE1]
    (res_data_ff[15:8] == {8{$past(opd_src1[7])}}))
    else $error("sign-extended load high byte wrong");
  chk_zext_load: assert property (is_ldze |=> res_wr_ff && // [RULE2]
    (res_data_ff[15:0] == {8'h00, $past(opd_src1[7:0])})) else $error("zero-extended load wrong");
  chk_long_short16: assert property (is_long_relative_branch && !ctrl_ff[0] |=> pc_load_ff && // [RULE3]
    (pc_ff[15:0] == $past(pc_next[15:0]) + $past(disp)))
    else $error("long branch target wrong");
  chk_signed_word: assert property (is_prod && prefixed && prod_w2 |=> // [RULE4]
    (res_data_ff == 32'($signed($past(opd_dst[15:0])) * $signed($past(opd_src1)))))
    else $error("signed word product wrong");
  chk_unsigned_word: assert property (is_prod && !prefixed && prod_w3 |=> // [RULE8]
    (res_data_ff == $past(opd_src1) * $past(opd_src2)))
    else $error("unsigned word product wrong");
  chk_mac_clear: assert property (mac_go && dst_addr[3] |=> // [RULE6]
    (acc_ff == res_data_ff)) else $error("accumulator not cleared before add");
  chk_flip_word: assert property (is_flip && !opcode[4] |=> // [RULE11]
    (res_data_ff[15:0] + $past(opd_dst[15:0]) == 16'h0000))
    else $error("negation wrong");
  chk_idle_flags: assert property (plain && (opcode == 8'hfd) |=> // [RULE12]
    $stable(processor_flag_word_ff) && !res_wr_ff && done_ff)
    else $error("idle changed state");
  chk_justify_zero: assert property (seq_justify_go |-> seq_justify_end) // [RULE14]
    else $error("justify of zero did not stop at 31");
  chk_inv_flags: assert property (is_inv |=> // [RULE15]
    !processor_flag_word_ff[3] && !processor_flag_word_ff[5] && !processor_flag_word_ff[4])
    else $error("complement flags wrong");
  chk_pop_step: assert property (is_popw && !reg_wr |=> // [RULE17]
    (sp_ff == $past(sp_ff) + 16'h0002) && (res_data_ff[15:0] == $past(stk_word0)))
    else $error("pop wrong");
  chk_restore_hold: assert property (is_restore ##1 !fin |=> irq_inhibit_ff) // [RULE20]
    else $error("interrupt hold dropped early");
  chk_push_store: assert property (is_pushw |=> mem_wr_ff && // [RULE21]
    (mem_addr_ff == sp_ff) && (mem_wdata_ff == $past(opd_src1)))
    else $error("push address or data wrong");
endmodule
`default_nettype wire

// *** hw/exec_subset_pkg.sv ***
// How it works
// RULE1: Sign-extending byte load fills high byte
// RULE2: Zero-extending byte load clears high byte
// RULE3: Long branch adds 16-bit displacement, mode-dependent
// RULE4: Prefixed two-operand word multiply is signed
// RULE5: Prefixed three-operand word multiply is signed
// RULE6: Low destination accumulates; address bit 3 clears
// RULE7: Prefixed byte multiplies are signed, word result
// RULE8: Unprefixed word multiplies are unsigned, doubleword
// RULE9: Unprefixed byte multiplies are unsigned, word result
// RULE10: Round flag undefined after any multiply
// RULE11: Flip opcodes negate word or byte operand
// RULE12: Idle opcode changes nothing, moves on
// RULE13: Justify shifts left, counts, clears carry
// RULE14: Still-zero top bit after 31 sets zero
// RULE15: Complement inverts, sets Z N, clears C V trap
// RULE16: Merge ORs operands, sets Z N, clears C V
// RULE17: Word pop reads stack, then pointer plus two
// RULE18: Full restore pops two words, pointer plus four
// RULE19: Flag restore pops flag pair, pointer plus two
// RULE20: No interrupt right after a context restore
// RULE21: Word push decrements pointer, then stores
// RULE22: Short branch sign-extends displacement to 24 bits
`default_nettype none
package exec_subset_pkg;
  localparam logic [7:0] OPC_PREFIX = 8'hfe;
  localparam logic [7:0] OPC_LONG_BR = 8'he7;
  localparam logic [7:0] OPC_FLIP_W = 8'h03;
  localparam logic [7:0] OPC_FLIP_B = 8'h13;
  localparam logic [7:0] OPC_IDLE = 8'hfd;
  localparam logic [7:0] OPC_JUSTIFY = 8'h0f;
  localparam logic [7:0] OPC_INV_W = 8'h02;
  localparam logic [7:0] OPC_INV_B = 8'h12;
  localparam logic [7:0] OPC_RESTORE_ALL = 8'hf5;
  localparam logic [7:0] OPC_RESTORE_FLAG = 8'hf3;
  localparam logic [3:0] OPN_SHORT_BR = 4'hd;
  localparam logic [5:0] OP6_LOAD_SEXT = 6'h2f;
  localparam logic [5:0] OP6_LOAD_ZEXT = 6'h2b;
  localparam logic [5:0] OP6_PROD_W2 = 6'h1b;
  localparam logic [5:0] OP6_PROD_W3 = 6'h13;
  localparam logic [5:0] OP6_PROD_B2 = 6'h1f;
  localparam logic [5:0] OP6_PROD_B3 = 6'h17;
  localparam logic [5:0] OP6_MERGE_W = 6'h20;
  localparam logic [5:0] OP6_MERGE_B = 6'h24;
  localparam logic [5:0] OP6_POP_W = 6'h33;
  localparam logic [5:0] OP6_PUSH_W = 6'h32;
  localparam logic [7:0] MAC_ADDR_TOP = 8'h0f;
  localparam int MAC_CLR_BIT = 3;
  localparam logic [4:0] JUSTIFY_MAX = 5'h1f;
  localparam logic [15:0] SP_STEP = 16'h0002;
  localparam logic [15:0] SP_STEP2 = 16'h0004;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [23:0] PC_RST = 24'h00_0000;
  localparam logic [7:0] PAIR_RST = 8'h00;
  localparam int FLG_Z = 7;
  localparam int FLG_N = 6;
  localparam int FLG_V = 5;
  localparam int FLG_TRAP = 4;
  localparam int FLG_C = 3;
  localparam int FLG_ROUND = 0;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ACC_LO = 4'h4;
  localparam logic [3:0] REG_ACC_HI = 4'h8;
  localparam logic [3:0] REG_SP = 4'hc;
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_MAC_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h2;
  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_NORM = 2'b10
  } state_e;
endpackage
`default_nettype wire

// *** hw/product_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module product_unit (
  // Operands
  input wire logic [15:0] a,
  input wire logic [15:0] b,
  input wire logic is_signed,
  input wire logic is_byte,
  // Result
  output logic [31:0] product
);
  logic [15:0] a_in;
  logic [15:0] b_in;
  logic signed [16:0] ax;
  logic signed [16:0] bx;
  logic signed [33:0] p;

  // Byte forms widen first, so one 17x17 multiplier serves all four
  assign a_in = is_byte ? {{8{is_signed & a[7]}}, a[7:0]} : a;
  assign b_in = is_byte ? {{8{is_signed & b[7]}}, b[7:0]} : b;
  assign ax = $signed({is_signed & a_in[15], a_in});
  assign bx = $signed({is_signed & b_in[15], b_in});
  assign p = ax * bx;
  assign product = p[31:0];
endmodule
`default_nettype wire

// *** tb/cpu_instr_exec_subset_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpu_instr_exec_subset_tb;
  localparam logic [31:0] z32 = 32'h0000_0000;
  localparam logic [15:0] z16 = 16'h0000;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic start = 1'b0;
  logic prefixed = 1'b0;
  logic cond_met = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [7:0] dst_addr = 8'h10;
  logic [31:0] opd_dst = z32;
  logic [15:0] opd_src1 = z16;
  logic [15:0] opd_src2 = z16;
  logic [15:0] disp = z16;
  logic [23:0] pc_next = 24'h00_0000;
  logic [15:0] stk_word0 = z16;
  logic [15:0] stk_word1 = z16;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = z32;
  logic busy_ff, done_ff, res_wr_ff, cnt_wr_ff, pc_load_ff, mem_wr_ff, irq_inhibit_ff;
  logic [1:0] res_size_ff;
  logic [31:0] res_data_ff, acc_ff, reg_rdata_ff, rd;
  logic [7:0] cnt_data_ff, processor_flag_word_ff, irq_enable_low_ff;
  logic [7:0] irq_enable_high_ff, window_select_reg_ff;
  logic [23:0] pc_ff;
  logic [15:0] sp_ff, mem_addr_ff, mem_wdata_ff;
  int bad_count = 0;
  int compares = 0;
  int lat;
  cpu_instr_exec_subset #(.HAS_MAC(1'b1)) i_cpu_instr_exec_subset (
    .sys_clk, .rst_b, .start, .opcode, .prefixed, .cond_met, .dst_addr, .opd_dst,
    .opd_src1, .opd_src2, .disp, .pc_next, .stk_word0, .stk_word1, .busy_ff, .done_ff,
    .res_wr_ff, .res_size_ff, .res_data_ff, .cnt_wr_ff, .cnt_data_ff, .pc_load_ff, .pc_ff,
    .sp_ff, .mem_wr_ff, .mem_addr_ff, .mem_wdata_ff, .processor_flag_word_ff,
    .irq_enable_low_ff, .irq_enable_high_ff, .window_select_reg_ff, .irq_inhibit_ff,
    .acc_ff, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff);
  always #2.5 sys_clk = ~sys_clk;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic ex(input logic [7:0] op, input logic pre, input logic [31:0] d,
                    input logic [15:0] s1, input logic [15:0] s2);
    @(posedge sys_clk);
    opcode <= op;
    prefixed <= pre;
    opd_dst <= d;
    opd_src1 <= s1;
    opd_src2 <= s2;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    #1;
    lat = 1;
    chk("busy", busy_ff, op == 8'h0f);
    while (done_ff !== 1'b1 && lat < 40) begin
      @(posedge sys_clk);
      #1;
      lat++;
    end
    chk("done", done_ff, 1'b1);
  endtask
  task automatic rw(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rr(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata_ff;
  endtask
  task automatic t_regs();
    chk("sp rst", sp_ff, z16);
    chk("size rst", res_size_ff, 2'h1);
    rr(4'h0);
    chk("ctrl rst", rd, 32'h0000_0002);
    rw(4'h4, 32'h1234_5678);
    rr(4'h4);
    chk("acc ro", rd, z32);
    rr(4'h2);
    chk("unmapped", rd, z32);
    $display("test regs done");
  endtask
  task automatic t_loads();
    ex(8'hbc, 1'b0, z32, 16'h1280, z16);
    chk("sext neg", res_data_ff[15:0], 16'hff80);
    ex(8'hbc, 1'b0, z32, 16'hff7f, z16);
    chk("sext pos", res_data_ff[15:0], 16'h007f);
    ex(8'hac, 1'b0, z32, 16'hff80, z16);
    chk("zext", res_data_ff[15:0], 16'h0080);
    ex(8'h6c, 1'b1, 32'h0000_ffff, 16'h0002, z16);
    chk("mul w2", res_data_ff, 32'hffff_fffe);
    chk("mul w2 sz", res_size_ff, 2'h2);
    ex(8'h4c, 1'b1, z32, 16'h8000, 16'h0002);
    chk("mul w3", res_data_ff, 32'hffff_0000);
    ex(8'h7c, 1'b1, 32'h0000_12ff, 16'hab03, z16);
    chk("mul b2", res_data_ff[15:0], 16'hfffd);
    ex(8'h5c, 1'b1, z32, 16'h0080, 16'h0002);
    chk("mul b3", res_data_ff[15:0], 16'hff00);
    ex(8'h6c, 1'b0, 32'h0000_ffff, 16'h0002, z16);
    chk("unsigned_product_16 w2", res_data_ff, 32'h0001_fffe);
    ex(8'h4c, 1'b0, z32, 16'h8000, 16'h0002);
    chk("unsigned_product_16 w3", res_data_ff, 32'h0001_0000);
    ex(8'h7c, 1'b0, 32'h0000_12ff, 16'hab03, z16);
    chk("unsigned_product_16 b2", res_data_ff[15:0], 16'h02fd);
    ex(8'h5c, 1'b0, z32, 16'h0080, 16'h0002);
    chk("unsigned_product_16 b3", res_data_ff[15:0], 16'h0100);
    $display("test loads and products done");
  endtask
  task automatic t_mac();
    @(posedge sys_clk);
    dst_addr <= 8'h08;
    ex(8'h4c, 1'b0, z32, 16'h0003, 16'h0004);
    chk("acc clr", acc_ff, 32'h0000_000c);
    @(posedge sys_clk);
    dst_addr <= 8'h00;
    ex(8'h4c, 1'b0, z32, 16'h0005, 16'h0006);
    chk("acc add", acc_ff, 32'h0000_002a);
    @(posedge sys_clk);
    dst_addr <= 8'h10;
    ex(8'h4c, 1'b0, z32, 16'h0005, 16'h0006);
    rr(4'h4);
    chk("acc high dst", rd, 32'h0000_002a);
    rr(4'h8);
    chk("acc hi", rd, z32);
    $display("test mac done");
  endtask
  task automatic t_branch();
    @(posedge sys_clk);
    pc_next <= 24'h00_1000;
    disp <= 16'h0100;
    ex(8'he7, 1'b0, z32, z16, z16);
    chk("long_relative_branch 64k", pc_ff, 24'h00_1100);
    chk("long_relative_branch load", pc_load_ff, 1'b1);
    rw(4'h0, 32'h0000_0003);
    @(posedge sys_clk);
    pc_next <= 24'h02_0004;
    disp <= 16'hfff0;
    ex(8'he7, 1'b0, z32, z16, z16);
    chk("long_relative_branch 1m", pc_ff, 24'h01_fff4);
    @(posedge sys_clk);
    disp <= 16'hff80;
    cond_met <= 1'b1;
    ex(8'hd7, 1'b0, z32, z16, z16);
    chk("sjmp", pc_ff, 24'h01_ff84);
    @(posedge sys_clk);
    cond_met <= 1'b0;
    ex(8'hd7, 1'b0, z32, z16, z16);
    chk("sjmp no", pc_ff, 24'h02_0004);
    $display("test branch done");
  endtask
  task automatic setf();
    @(posedge sys_clk);
    stk_word0 <= 16'hff5a;
    ex(8'hf3, 1'b0, z32, z16, z16);
  endtask
  task automatic t_flags();
    rw(4'hc, 32'h0000_0100);
    setf();
    chk("restore_flag_word", {processor_flag_word_ff, irq_enable_low_ff}, 16'hff5a);
    chk("restore_flag_word sp", sp_ff, 16'h0102);
    chk("restore_flag_word inh", irq_inhibit_ff, 1'b1);
    @(posedge sys_clk);
    pc_next <= 24'h02_0010;
    ex(8'hfd, 1'b0, z32, z16, z16);
    chk("idle flags", processor_flag_word_ff, 8'hff);
    chk("idle wr", res_wr_ff, 1'b0);
    chk("idle pc", pc_ff, 24'h02_0010);
    chk("inh clr", irq_inhibit_ff, 1'b0);
    ex(8'h02, 1'b0, 32'h0000_00ff, z16, z16);
    chk("not w", res_data_ff[15:0], 16'hff00);
    chk("not w fl", processor_flag_word_ff[7:3], 5'h08);
    ex(8'h12, 1'b0, 32'h0000_00ff, z16, z16);
    chk("not b", res_data_ff[7:0], 8'h00);
    chk("not b fl", processor_flag_word_ff[7:3], 5'h10);
    setf();
    ex(8'h80, 1'b0, 32'h0000_8000, 16'h0001, z16);
    chk("or w", res_data_ff[15:0], 16'h8001);
    chk("or w fl", processor_flag_word_ff[7:3], 5'h0a);
    ex(8'h90, 1'b0, 32'h0000_ff00, 16'hff00, z16);
    chk("or b fl", processor_flag_word_ff[7:3], 5'h12);
    ex(8'h03, 1'b0, 32'h0000_0001, z16, z16);
    chk("neg w", res_data_ff[15:0], 16'hffff);
    ex(8'h13, 1'b0, 32'h0000_0001, z16, z16);
    chk("neg b", res_data_ff[7:0], 8'hff);
    setf();
    ex(8'h0f, 1'b0, 32'h0000_0100, z16, z16);
    chk("norm val", res_data_ff, 32'h8000_0000);
    chk("norm cnt", {cnt_wr_ff, cnt_data_ff}, 9'h117);
    chk("norm cz", {processor_flag_word_ff[7], processor_flag_word_ff[3]}, 2'h0);
    chk("norm lat", lat, 25);
    ex(8'h0f, 1'b0, z32, z16, z16);
    chk("norm max", cnt_data_ff, 8'h1f);
    chk("norm z", processor_flag_word_ff[7], 1'b1);
    ex(8'h0f, 1'b0, 32'h8000_0000, z16, z16);
    chk("norm none", {cnt_data_ff, processor_flag_word_ff[7]}, 9'h000);
    $display("test flags done");
  endtask
  task automatic t_stack();
    rw(4'hc, 32'h0000_0200);
    ex(8'hc8, 1'b0, z32, 16'hbeef, z16);
    chk("push sp", sp_ff, 16'h01fe);
    chk("push", {mem_addr_ff, mem_wdata_ff}, 32'h01fe_beef);
    chk("push wr", mem_wr_ff, 1'b1);
    @(posedge sys_clk);
    stk_word0 <= 16'ha1b2;
    stk_word1 <= 16'hc3d4;
    ex(8'hcc, 1'b0, z32, z16, z16);
    chk("pop", {res_data_ff[15:0], sp_ff}, 32'ha1b2_0200);
    ex(8'hf5, 1'b0, z32, z16, z16);
    chk("restore_all_context hi", {irq_enable_high_ff, window_select_reg_ff}, 16'ha1b2);
    chk("restore_all_context lo", {processor_flag_word_ff, irq_enable_low_ff}, 16'hc3d4);
    chk("restore_all_context sp", sp_ff, 16'h0204);
    rr(4'hc);
    chk("sp rd", rd, 32'h0000_0204);
    setf();
    chk("inh chain", irq_inhibit_ff, 1'b1);
    ex(8'hfd, 1'b0, z32, z16, z16);
    chk("inh end", irq_inhibit_ff, 1'b0);
    $display("test stack done");
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs();
    t_loads();
    t_mac();
    t_branch();
    t_flags();
    t_stack();
    tally_and_finish();
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    bad_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
